//--- shared/icu_pkg.sv
// Purpose: Shared constants and types of the input capture unit.
// Assumes: 32-bit APB, one word per register.
// Notes: Register offsets are byte addresses.
package icu_pkg;
    // Register byte offsets.
    localparam logic [7:0] ICU_OFS_CON1 = 8'h00;
    localparam logic [7:0] ICU_OFS_CON2 = 8'h04;
    localparam logic [7:0] ICU_OFS_BUF = 8'h08;
    localparam logic [7:0] ICU_OFS_TMR = 8'h0C;
    // Field positions of the first control register.
    localparam int ICU_SIDL_BIT = 13;
    localparam int ICU_TSEL_LSB = 10;
    localparam int ICU_EPI_LSB = 5;
    localparam int ICU_OVF_BIT = 4;
    localparam int ICU_BNE_BIT = 3;
    localparam int ICU_MODE_LSB = 0;
    // Field positions of the second control register.
    localparam int ICU_CASC_BIT = 8;
    localparam int ICU_TRIGOP_BIT = 7;
    localparam int ICU_TSTAT_BIT = 6;
    localparam int ICU_SSEL_LSB = 0;
    // Reset values and software-writable bit masks.
    localparam logic [15:0] ICU_CON1_RST = 16'h0000;
    localparam logic [15:0] ICU_CON2_RST = 16'h000D;
    localparam logic [15:0] ICU_CON1_WMASK = 16'h3C67;
    localparam logic [15:0] ICU_CON2_WMASK = 16'h019F;
    // Capture mode codes.
    typedef enum logic [2:0] {
        MODE_OFF = 3'h0, MODE_EDGE = 3'h1, MODE_RISE = 3'h2, MODE_FALL = 3'h3,
        MODE_PRE4 = 3'h4, MODE_PRE16 = 3'h5, MODE_UNUSED = 3'h6, MODE_INTPIN = 3'h7
    } icu_mode_t;
    // Time base codes; 3'h5 and 3'h6 are reserved.
    localparam logic [2:0] TB_TMR3 = 3'h0;
    localparam logic [2:0] TB_TMR2 = 3'h1;
    localparam logic [2:0] TB_TMR4 = 3'h2;
    localparam logic [2:0] TB_TMR5 = 3'h3;
    localparam logic [2:0] TB_TMR1 = 3'h4;
    localparam logic [2:0] TB_PCLK = 3'h7;
    // Timer state: held at zero or running.
    typedef enum logic {TRG_HELD = 1'b0, TRG_RUN = 1'b1} icu_trig_t;
    // APB request and answer carriers.
    typedef struct packed {
        logic psel;
        logic penable;
        logic pwrite;
        logic [7:0] paddr;
        logic [31:0] pwdata;
    } icu_apb_req_t;
    typedef struct packed {
        logic [31:0] prdata;
        logic pready;
        logic pslverr;
    } icu_apb_rsp_t;
endpackage : icu_pkg

//--- rtl/icu_fifo.sv
// Purpose: Capture buffer holding timestamps oldest first.
// Assumes: Push is never asked while full.
// Notes: Flush empties the buffer in one cycle.
module icu_fifo #(
    parameter int W = 32,
    parameter int D = 4
) (
    input wire logic i_ref_clk,
    input wire logic i_resetn,
    input wire logic i_flush,
    input wire logic i_push,
    input wire logic [W-1:0] i_data,
    input wire logic i_pop,
    output logic [W-1:0] o_head,
    output logic o_full,
    output logic o_empty
);
    localparam int AW = $clog2(D);
    // Storage words and pointers with a wrap bit.
    logic [W-1:0] mem_ff [D];
    logic [AW:0] wp_ff, nxt_wp, rp_ff, nxt_rp;

    // Full when pointers differ in the wrap bit only.
    assign o_empty = (wp_ff == rp_ff);
    assign o_full = (wp_ff[AW] != rp_ff[AW]) && (wp_ff[AW-1:0] == rp_ff[AW-1:0]);
    assign o_head = mem_ff[rp_ff[AW-1:0]];

    // Pointer next values.
    always_comb begin
        nxt_wp = wp_ff;
        nxt_rp = rp_ff;
        if (i_flush) begin
            nxt_rp = wp_ff;
        end else begin
            if (i_push && !o_full) begin
                nxt_wp = wp_ff + {{AW{1'b0}}, 1'b1};
            end
            if (i_pop && !o_empty) begin
                nxt_rp = rp_ff + {{AW{1'b0}}, 1'b1};
            end
        end
    end

    // Pointer registers.
    always_ff @(posedge i_ref_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            wp_ff <= '0;
            rp_ff <= '0;
        end else begin
            wp_ff <= nxt_wp;
            rp_ff <= nxt_rp;
        end
    end

    // Storage write; contents need no reset.
    always_ff @(posedge i_ref_clk) begin
        if (i_push && !o_full && !i_flush) begin
            mem_ff[wp_ff[AW-1:0]] <= i_data;
        end
    end
endmodule : icu_fifo

//--- rtl/icu_edge.sv
// Purpose: Edge detection and prescaling of the capture pin.
// Assumes: Pin is synchronous to the clock.
// Notes: Prescaler restarts whenever the unit is disabled.
module icu_edge
    import icu_pkg::*;
(
    input wire logic i_ref_clk,
    input wire logic i_resetn,
    input wire logic i_enable,
    input wire logic i_pin,
    input wire icu_mode_t i_mode,
    output logic o_capture,
    output logic o_rise
);
    // Previous pin level and rising edge prescaler.
    logic pin_ff, nxt_pin;
    logic [3:0] pre_ff, nxt_pre;
    logic fall;
    logic [3:0] lim;

    assign o_rise = i_pin && !pin_ff;
    assign fall = !i_pin && pin_ff;
    assign lim = (i_mode == MODE_PRE16) ? 4'hF : 4'h3;

    // Capture decision and prescaler next value.
    always_comb begin
        nxt_pin = i_pin;
        nxt_pre = pre_ff;
        o_capture = 1'b0;
        if (!i_enable) begin
            nxt_pre = 4'h0;
        end else begin
            case (i_mode)
                MODE_EDGE: o_capture = o_rise || fall;
                MODE_RISE: o_capture = o_rise;
                MODE_FALL: o_capture = fall;
                MODE_PRE4, MODE_PRE16: begin
                    // Every fourth or sixteenth rise is taken.
                    if (o_rise) begin
                        o_capture = (pre_ff >= lim);
                        nxt_pre = (pre_ff >= lim) ? 4'h0 : pre_ff + 4'h1;
                    end
                end
                default: o_capture = 1'b0;
            endcase
        end
    end

    // State registers.
    always_ff @(posedge i_ref_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            pin_ff <= 1'b0;
            pre_ff <= 4'h0;
        end else begin
            pin_ff <= nxt_pin;
            pre_ff <= nxt_pre;
        end
    end

    // Prescaled capture only on the counted rise.
    property p_pre_count;
        @(posedge i_ref_clk) disable iff (!i_resetn)
        (o_capture && i_mode == MODE_PRE4) |-> (pre_ff >= 4'h3) && o_rise;
    endproperty
    a_pre_count: assert property (p_pre_count) else $error("prescale count wrong");
endmodule : icu_edge

//--- rtl/icu_capture_unit.sv
// Purpose: Input capture unit with APB registers and capture buffer.
// Assumes: All inputs are synchronous to i_ref_clk.
// Notes: Zero wait APB; read data is prepared in the setup cycle.

module icu_capture_unit
    import icu_pkg::*;
#(
    parameter int DEPTH = 4
) (
    input wire logic i_ref_clk,
    input wire logic i_resetn,
    input wire icu_apb_req_t i_apb,
    output icu_apb_rsp_t o_apb,
    input wire logic i_cap_pin,
    input wire logic i_cpu_idle,
    input wire logic [4:0] i_tb_tick,
    input wire logic [31:0] i_sync_src,
    input wire logic [15:0] i_partner_timer,
    input wire logic i_partner_cascade,
    output logic [15:0] o_timer,
    output logic o_cascade,
    output logic o_capture_irq
);
    // Registered state.
    logic [15:0] con1_ff, nxt_con1; // Writable bits of control one.
    logic [15:0] con2_ff, nxt_con2; // Writable bits of control two.
    icu_trig_t trig_ff, nxt_trig; // Trigger status.
    logic [15:0] tmr_ff, nxt_tmr; // Unit timer.
    logic [1:0] evt_ff, nxt_evt; // Captures since last interrupt.
    logic ovf_ff, nxt_ovf; // Overflow flag.
    logic irq_ff, nxt_irq; // Interrupt request pulse.
    logic [31:0] rdata_ff, nxt_rdata; // Read data for the access phase.
    logic err_ff, nxt_err; // Unmapped address seen in setup.
    logic popok_ff, nxt_popok; // Setup read took a real buffer word.
    logic pin_q_ff; // Pin one cycle late, for checking only.

    // Decoded fields.
    icu_mode_t mode;
    logic [2:0] tb_sel;
    logic [1:0] epi;
    logic sidl, casc, trig_op, src, tick, halt, cap_mode;
    logic [4:0] ssel;
    // Capture path.
    logic cap, rise, push, pop, full, empty, casc_on;
    logic [31:0] cap_val, head;
    // Bus decode.
    logic setup, access, wr_en;

    // Pick the tick enable of the selected time base.
    function automatic logic tb_tick(input logic [2:0] sel, input logic [4:0] t);
        logic r;
        r = 1'b0;
        case (sel)
            TB_PCLK: r = 1'b1;
            TB_TMR1: r = t[0];
            TB_TMR2: r = t[1];
            TB_TMR3: r = t[2];
            TB_TMR4: r = t[3];
            TB_TMR5: r = t[4];
            default: r = 1'b0;
        endcase
        return r;
    endfunction : tb_tick

    // Word address match with alignment check.
    function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
        return a == ofs;
    endfunction : hit

    // Field decode from the control registers.
    assign mode = icu_mode_t'(con1_ff[ICU_MODE_LSB +: 3]);
    assign tb_sel = con1_ff[ICU_TSEL_LSB +: 3];
    assign epi = con1_ff[ICU_EPI_LSB +: 2];
    assign sidl = con1_ff[ICU_SIDL_BIT];
    assign casc = con2_ff[ICU_CASC_BIT];
    assign trig_op = con2_ff[ICU_TRIGOP_BIT];
    assign ssel = con2_ff[ICU_SSEL_LSB +: 5];

    // Source selection; the unit's own index must not be chosen.
    assign src = i_sync_src[ssel];
    assign tick = tb_tick(tb_sel, i_tb_tick);
    // Halt in idle when stop-in-idle is set.
    assign halt = sidl && i_cpu_idle;
    // Capture modes exclude off, unused and wake-only codes.
    assign cap_mode = !(mode inside {MODE_OFF, MODE_UNUSED, MODE_INTPIN});

    // Cascade needs both neighbours set; upper half from the odd partner.
    assign casc_on = casc && i_partner_cascade;
    assign cap_val = casc_on ? {i_partner_timer, tmr_ff} : {16'h0000, tmr_ff};

    // Bus phases.
    assign setup = i_apb.psel && !i_apb.penable;
    assign access = i_apb.psel && i_apb.penable;
    assign wr_en = access && i_apb.pwrite && !err_ff;
    assign pop = access && !i_apb.pwrite && popok_ff;
    assign push = cap && !full;

    // Edge detection and prescaler.
    icu_edge u_edge (
        .i_ref_clk(i_ref_clk),
        .i_resetn(i_resetn),
        .i_enable(cap_mode && !halt),
        .i_pin(i_cap_pin),
        .i_mode(mode),
        .o_capture(cap),
        .o_rise(rise)
    );

    // Capture buffer, flushed while the mode is off, unused or wake-only.
    icu_fifo #(
        .W(32),
        .D(DEPTH)
    ) u_fifo (
        .i_ref_clk(i_ref_clk),
        .i_resetn(i_resetn),
        .i_flush(!cap_mode),
        .i_push(push),
        .i_data(cap_val),
        .i_pop(pop),
        .o_head(head),
        .o_full(full),
        .o_empty(empty)
    );

    // Register file, bus answer and read data next values.
    always_comb begin
        nxt_con1 = con1_ff;
        nxt_con2 = con2_ff;
        nxt_rdata = rdata_ff;
        nxt_err = err_ff;
        nxt_popok = 1'b0;
        if (setup) begin
            // Read data is taken in the setup cycle.
            nxt_err = 1'b0;
            nxt_rdata = 32'h0000_0000;
            if (hit(i_apb.paddr, ICU_OFS_CON1)) begin
                nxt_rdata[15:0] = con1_ff;
                nxt_rdata[ICU_OVF_BIT] = ovf_ff;
                nxt_rdata[ICU_BNE_BIT] = !empty;
            end else if (hit(i_apb.paddr, ICU_OFS_CON2)) begin
                nxt_rdata[15:0] = con2_ff;
                nxt_rdata[ICU_TSTAT_BIT] = (trig_ff == TRG_RUN);
            end else if (hit(i_apb.paddr, ICU_OFS_BUF)) begin
                nxt_rdata = empty ? 32'h0000_0000 : head;
                nxt_popok = !i_apb.pwrite && !empty;
            end else if (hit(i_apb.paddr, ICU_OFS_TMR)) begin
                nxt_rdata[15:0] = tmr_ff;
            end else begin
                nxt_err = 1'b1;
            end
        end
        if (wr_en) begin
            if (hit(i_apb.paddr, ICU_OFS_CON1)) begin
                nxt_con1 = i_apb.pwdata[15:0] & ICU_CON1_WMASK;
            end else if (hit(i_apb.paddr, ICU_OFS_CON2)) begin
                nxt_con2 = i_apb.pwdata[15:0] & ICU_CON2_WMASK;
            end
        end
    end

    // Control register and bus answer flops.
    always_ff @(posedge i_ref_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            con1_ff <= ICU_CON1_RST;
            con2_ff <= ICU_CON2_RST & ICU_CON2_WMASK;
            rdata_ff <= 32'h0000_0000;
            err_ff <= 1'b0;
            popok_ff <= 1'b0;
        end else begin
            con1_ff <= nxt_con1;
            con2_ff <= nxt_con2;
            rdata_ff <= nxt_rdata;
            err_ff <= nxt_err;
            popok_ff <= nxt_popok;
        end
    end

    // Timer, trigger, grouping, overflow and interrupt next values.
    always_comb begin
        nxt_trig = trig_ff;
        nxt_tmr = tmr_ff;
        nxt_evt = evt_ff;
        nxt_ovf = ovf_ff;
        nxt_irq = 1'b0;
        // Software may set or clear the trigger status.
        if (wr_en && hit(i_apb.paddr, ICU_OFS_CON2)) begin
            nxt_trig = i_apb.pwdata[ICU_TSTAT_BIT] ? TRG_RUN : TRG_HELD;
        end
        // The selected source sets it; this wins over a clear.
        if (trig_op && src && cap_mode) begin
            nxt_trig = TRG_RUN;
        end
        // Timer: cleared when off or untriggered, held when halted, cleared on sync, else counts on tick.
        if (!cap_mode || (trig_op && trig_ff == TRG_HELD)) begin
            nxt_tmr = 16'h0000;
        end else if (halt) begin
            nxt_tmr = tmr_ff;
        end else if (!trig_op && src) begin
            nxt_tmr = 16'h0000;
        end else if (tick) begin
            nxt_tmr = tmr_ff + 16'h0001;
        end
        // Interrupt grouping.
        case (mode)
            MODE_INTPIN: nxt_irq = rise;
            MODE_EDGE: nxt_irq = cap;
            default: begin
                if (cap) begin
                    nxt_irq = (evt_ff == epi);
                    nxt_evt = (evt_ff == epi) ? 2'h0 : evt_ff + 2'h1;
                end
            end
        endcase
        if (!cap_mode || mode == MODE_EDGE) begin
            nxt_evt = 2'h0;
        end
        // Overflow: set on a capture into a full buffer, cleared once drained.
        if (cap && full) begin
            nxt_ovf = 1'b1;
        end else if (!cap_mode || empty) begin
            nxt_ovf = 1'b0;
        end
    end

    // State flops.
    always_ff @(posedge i_ref_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            trig_ff <= TRG_HELD;
            tmr_ff <= 16'h0000;
            evt_ff <= 2'h0;
            ovf_ff <= 1'b0;
            irq_ff <= 1'b0;
            pin_q_ff <= 1'b0;
        end else begin
            trig_ff <= nxt_trig;
            tmr_ff <= nxt_tmr;
            evt_ff <= nxt_evt;
            ovf_ff <= nxt_ovf;
            irq_ff <= nxt_irq;
            pin_q_ff <= i_cap_pin;
        end
    end

    // Outputs.
    assign o_apb.prdata = rdata_ff;
    assign o_apb.pready = 1'b1;
    assign o_apb.pslverr = err_ff;
    assign o_timer = tmr_ff;
    assign o_cascade = casc;
    assign o_capture_irq = irq_ff;

    // Checks.
    default clocking cb @(posedge i_ref_clk);
    endclocking
    default disable iff (!i_resetn);

    property p_off_quiet;
        (mode == MODE_OFF || mode == MODE_UNUSED) |-> !cap ##1 (tmr_ff == 16'h0000);
    endproperty
    a_off_quiet: assert property (p_off_quiet) else $error("disabled unit active");

    property p_both_edges;
        (mode == MODE_EDGE && !halt && $changed(i_cap_pin) && pin_q_ff != i_cap_pin) |-> cap ##1 o_capture_irq;
    endproperty
    a_both_edges: assert property (p_both_edges) else $error("edge mode missed edge");

    property p_fall_only;
        (mode == MODE_FALL && cap) |-> (pin_q_ff && !i_cap_pin);
    endproperty
    a_fall_only: assert property (p_fall_only) else $error("fall mode took wrong edge");

    property p_wake_pin;
        (mode == MODE_INTPIN && !pin_q_ff && i_cap_pin) |-> !push ##1 o_capture_irq;
    endproperty
    a_wake_pin: assert property (p_wake_pin) else $error("wake mode wrong");

    property p_group;
        (o_capture_irq && $past(mode) inside {MODE_RISE, MODE_FALL, MODE_PRE4, MODE_PRE16})
            |-> $past(evt_ff) == $past(epi) && evt_ff == 2'h0;
    endproperty
    a_group: assert property (p_group) else $error("group interrupt count wrong");

    property p_ovf_set;
        (cap && full) |=> ovf_ff && !empty;
    endproperty
    a_ovf_set: assert property (p_ovf_set) else $error("overflow not flagged");

    property p_push_fills;
        (push && cap_mode) |=> !empty;
    endproperty
    a_push_fills: assert property (p_push_fills) else $error("capture not buffered");

    property p_idle_hold;
        (halt && cap_mode && !(trig_op && trig_ff == TRG_HELD)) |=> tmr_ff == $past(tmr_ff);
    endproperty
    a_idle_hold: assert property (p_idle_hold) else $error("timer ran while halted");

    property p_held_zero;
        (trig_op && trig_ff == TRG_HELD) |=> tmr_ff == 16'h0000;
    endproperty
    a_held_zero: assert property (p_held_zero) else $error("held timer not zero");

    property p_hw_set_wins;
        (trig_op && src && cap_mode) |=> trig_ff == TRG_RUN;
    endproperty
    a_hw_set_wins: assert property (p_hw_set_wins) else $error("trigger not set");

    property p_reserved_tb;
        ((tb_sel == 3'h5 || tb_sel == 3'h6) && cap_mode && !src && !(trig_op && trig_ff == TRG_HELD))
            |=> tmr_ff == $past(tmr_ff);
    endproperty
    a_reserved_tb: assert property (p_reserved_tb) else $error("reserved base ticked");
endmodule : icu_capture_unit

//--- verification/icu_pin_model.sv
// Purpose: Drives the capture pin the way an external edge source would.
// Assumes: The pin level changes just after a rising clock edge.
// Notes: The pin rests low between bursts.
module icu_pin_model (
    input wire logic i_ref_clk,
    output logic o_pin
);
    timeunit 1ns;
    timeprecision 1ps;
    // Start low so that leaving reset shows no edge.
    initial o_pin = 1'b0;
    // Send n whole pulses, each level held for half cycles.
    task automatic run(input int n, input int half);
        for (int i = 0; i < 2 * n; i++) begin
            @(posedge i_ref_clk);
            o_pin <= ~o_pin;
            repeat (half - 1) @(posedge i_ref_clk);
        end
    endtask : run
endmodule : icu_pin_model

//--- verification/icu_capture_unit_tb_top.sv
// Purpose: Self-checking bench of the input capture unit.
// Assumes: Zero wait APB slave and a 125 MHz clock.
// Notes: The capture buffer is enlarged to 32 words.
module icu_capture_unit_tb_top
    import icu_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic i_ref_clk;
    logic i_resetn = 1'b0;
    icu_apb_req_t req = '0;
    icu_apb_rsp_t rsp;
    logic idle = 1'b0;
    logic [4:0] tick = '0;
    logic [31:0] src = '0;
    logic [15:0] ptmr = '0;
    logic pcasc = 1'b0;
    logic [15:0] tmr;
    logic casc;
    logic irq;
    logic pin;
    logic err;
    logic [31:0] rd;
    logic [31:0] prev;
    int miscompares = 0;
    int samples_checked = 0;
    int irq_cnt = 0;
    int base;
    int n;
    // Timer input bit expected for time base codes 0 to 4.
    int tb_bit[5] = '{2, 1, 3, 4, 0};
    // Columns: mode, grouping, stop in idle, idle, pulses, captures, interrupts, overflow.
    int tbl[14][8] = '{'{0, 0, 0, 0, 8, 0, 0, 0}, '{6, 0, 0, 0, 8, 0, 0, 0},
        '{1, 3, 0, 0, 8, 16, 16, 0}, '{2, 0, 0, 0, 8, 8, 8, 0},
        '{3, 0, 0, 0, 8, 8, 8, 0}, '{4, 0, 0, 0, 16, 4, 4, 0},
        '{5, 0, 0, 0, 16, 1, 1, 0}, '{7, 3, 1, 1, 8, 0, 8, 0},
        '{2, 1, 0, 0, 12, 12, 6, 0}, '{2, 2, 0, 0, 12, 12, 4, 0},
        '{2, 3, 0, 0, 12, 12, 3, 0}, '{2, 0, 1, 1, 8, 0, 0, 0},
        '{2, 0, 0, 1, 8, 8, 8, 0}, '{1, 0, 0, 0, 20, 32, -1, 1}};

    icu_capture_unit #(.DEPTH(32)) uut (.i_ref_clk(i_ref_clk), .i_resetn(i_resetn), .i_apb(req), .o_apb(rsp),
        .i_cap_pin(pin), .i_cpu_idle(idle), .i_tb_tick(tick), .i_sync_src(src), .i_partner_timer(ptmr),
        .i_partner_cascade(pcasc), .o_timer(tmr), .o_cascade(casc), .o_capture_irq(irq));
    icu_pin_model pin_src (.i_ref_clk(i_ref_clk), .o_pin(pin));

    // Free running 8 ns clock.
    initial begin
        i_ref_clk = 1'b0;
        forever #4 i_ref_clk = ~i_ref_clk;
    end
    // Counts interrupt pulses; scenarios take differences.
    always @(posedge i_ref_clk) begin
        if (irq === 1'b1) irq_cnt <= irq_cnt + 1;
    end

    // Compares one value and counts the outcome.
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            miscompares++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    // One APB transfer: setup, access held until pready, then release.
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        int w;
        w = 0;
        @(posedge i_ref_clk);
        req <= '{psel: 1'b1, penable: 1'b0, pwrite: wr, paddr: a, pwdata: d};
        @(posedge i_ref_clk);
        req.penable <= 1'b1;
        do begin
            @(posedge i_ref_clk);
            w++;
        end while (rsp.pready !== 1'b1 && w < 50);
        if (w >= 50) miscompares++;
        rd = rsp.prdata;
        err = rsp.pslverr;
        req.psel <= 1'b0;
        req.penable <= 1'b0;
    endtask : apb
    // Pulses one sync or trigger source line for a cycle.
    task automatic pulse(input logic [31:0] v);
        @(posedge i_ref_clk);
        src <= v;
        @(posedge i_ref_clk);
        src <= '0;
    endtask : pulse
    // Reads the timer twice back to back and checks the step.
    task automatic tstep(input logic [31:0] exp);
        apb(1'b0, ICU_OFS_TMR, '0);
        prev = rd;
        apb(1'b0, ICU_OFS_TMR, '0);
        check(rd - prev, exp);
    endtask : tstep
    // Prints the counts and the verdict, then stops.
    task automatic end_of_test();
        $display("checks %0d mismatches %0d", samples_checked, miscompares);
        if (miscompares == 0 && samples_checked > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : end_of_test

    // Watchdog cuts a hang short well past the expected run length.
    initial begin
        #160000;
        miscompares++;
        end_of_test();
    end

    // Main sequence.
    initial begin
        repeat (8) @(posedge i_ref_clk);
        i_resetn <= 1'b1;
        apb(1'b0, ICU_OFS_CON1, '0);
        check(rd, 32'h0000_0000);
        apb(1'b0, ICU_OFS_CON2, '0);
        check(rd, 32'h0000_000D);
        apb(1'b0, 8'h10, '0);
        check({rd[30:0], err}, 32'h0000_0001);
        apb(1'b1, ICU_OFS_CON1, 32'hFFFF_FFFF);
        apb(1'b0, ICU_OFS_CON1, '0);
        check(rd, 32'h0000_3C67);
        apb(1'b1, ICU_OFS_CON2, 32'hFFFF_FFFF);
        apb(1'b0, ICU_OFS_CON2, '0);
        check({rd[30:0], casc}, {31'h0000_01DF, 1'b1});
        apb(1'b1, ICU_OFS_CON2, 32'h0000_000D);
        // Codes 0 to 4 advance on their own timer input; reserved codes 5 and 6 never advance.
        for (int c = 0; c < 7; c++) begin
            tick <= (c < 5) ? 5'(1 << tb_bit[c]) : 5'h1F;
            apb(1'b1, ICU_OFS_CON1, 32'((c << ICU_TSEL_LSB) | 2));
            @(posedge i_ref_clk);
            prev = 32'(tmr);
            repeat (6) @(posedge i_ref_clk);
            check(32'(tmr) - prev, (c < 5) ? 6 : 0);
        end
        apb(1'b1, ICU_OFS_CON1, 32'h0000_1C02);
        tstep(32'h3);
        // Trigger mode: held at zero until the selected source fires.
        apb(1'b1, ICU_OFS_CON2, 32'h0000_0085);
        apb(1'b0, ICU_OFS_TMR, '0);
        check(rd, '0);
        pulse(32'h0000_0010);
        apb(1'b0, ICU_OFS_CON2, '0);
        check(rd, 32'h0000_0085);
        pulse(32'h0000_0020);
        apb(1'b0, ICU_OFS_CON2, '0);
        check(rd, 32'h0000_00C5);
        tstep(32'h3);
        apb(1'b1, ICU_OFS_CON2, 32'h0000_0085);
        apb(1'b0, ICU_OFS_TMR, '0);
        check(rd, '0);
        apb(1'b1, ICU_OFS_CON2, 32'h0000_00C5);
        tstep(32'h3);
        // Sync mode: the source pulse restarts a running timer.
        apb(1'b1, ICU_OFS_CON2, 32'h0000_0005);
        repeat (40) @(posedge i_ref_clk);
        pulse(32'h0000_0020);
        apb(1'b0, ICU_OFS_TMR, '0);
        check(rd < 8, 1);
        apb(1'b1, ICU_OFS_CON2, 32'h0000_000D);
        // Capture mode table: counts, grouping, idle, overflow, timestamps.
        for (int i = 0; i < 14; i++) begin
            apb(1'b1, ICU_OFS_CON1, '0);
            idle <= tbl[i][3][0];
            apb(1'b1, ICU_OFS_CON1, 32'((tbl[i][2] << ICU_SIDL_BIT) | (7 << ICU_TSEL_LSB)
                | (tbl[i][1] << ICU_EPI_LSB) | tbl[i][0]));
            base = irq_cnt;
            pin_src.run(tbl[i][4], 2);
            repeat (8) @(posedge i_ref_clk);
            if (tbl[i][6] >= 0) check(irq_cnt - base, tbl[i][6]);
            apb(1'b0, ICU_OFS_CON1, '0);
            check(rd[ICU_OVF_BIT], tbl[i][7]);
            check(rd[ICU_BNE_BIT], tbl[i][5] != 0);
            n = 0;
            while (rd[ICU_BNE_BIT] === 1'b1 && n < 40) begin
                apb(1'b0, ICU_OFS_BUF, '0);
                if (tbl[i][0] == 2 && n > 0) check(rd - prev, 32'h4);
                prev = rd;
                n++;
                apb(1'b0, ICU_OFS_CON1, '0);
            end
            check(n, tbl[i][5]);
            check(rd[ICU_OVF_BIT], 0);
            idle <= 1'b0;
        end
        // Cascade: the upper half of a capture comes from the neighbour.
        ptmr <= 16'hA5C3;
        pcasc <= 1'b1;
        apb(1'b1, ICU_OFS_CON2, 32'h0000_010D);
        apb(1'b1, ICU_OFS_CON1, '0);
        apb(1'b1, ICU_OFS_CON1, 32'h0000_1C02);
        pin_src.run(1, 2);
        repeat (4) @(posedge i_ref_clk);
        apb(1'b0, ICU_OFS_BUF, '0);
        check(rd[31:16], 32'h0000_A5C3);
        end_of_test();
    end
endmodule : icu_capture_unit_tb_top
